// File: rail_fault_defines.svh
// Register offsets, field positions and reset values of the fault mask block
`ifndef RAIL_FAULT_DEFINES_SVH
`define RAIL_FAULT_DEFINES_SVH

// Register offsets on the serial control bus
`define REGULATOR_MASK_ADDR 8'h17
`define CONVERTER_MASK_ADDR 8'h18

// Reset values
`define MASK_RESET_VALUE    8'h00
`define READ_IDLE_VALUE     8'h00

// Regulator mask register fields
`define REG4_OVERVOLT_BIT   7
`define REG3_OVERVOLT_BIT   6
`define REG2_OVERVOLT_BIT   5
`define REG1_OVERVOLT_BIT   4
`define REG4_UNDERVOLT_BIT  3
`define REG3_UNDERVOLT_BIT  2
`define REG2_UNDERVOLT_BIT  1
`define REG1_UNDERVOLT_BIT  0

// Converter mask register fields
`define STEPUP_OVERVOLT_BIT    7
`define STEPDOWN_OVERVOLT_BIT  6
`define STEPUP_UNDERVOLT_BIT   5
`define STEPDOWN_UNDERVOLT_BIT 4
`define REG4_OVERCURRENT_BIT   3
`define REG3_OVERCURRENT_BIT   2
`define REG2_OVERCURRENT_BIT   1
`define REG1_OVERCURRENT_BIT   0

`endif

// File: rail_fault_pkg.sv
// Types shared by the fault mask block
package rail_fault_pkg;

    typedef logic [7:0] byte_t;

    // Regulator mask register layout
    typedef struct packed {
        logic reg4_overvolt_mask;
        logic reg3_overvolt_mask;
        logic reg2_overvolt_mask;
        logic reg1_overvolt_mask;
        logic reg4_undervolt_mask;
        logic reg3_undervolt_mask;
        logic reg2_undervolt_mask;
        logic reg1_undervolt_mask;
    } regulator_mask_t;

    // Converter mask register layout
    typedef struct packed {
        logic stepup_overvolt_mask;
        logic stepdown_overvolt_mask;
        logic stepup_undervolt_mask;
        logic stepdown_undervolt_mask;
        logic reg4_overcurrent_mask;
        logic reg3_overcurrent_mask;
        logic reg2_overcurrent_mask;
        logic reg1_overcurrent_mask;
    } converter_mask_t;

endpackage

// File: mask_bus_if.sv
// Carrier between the mask core and its register file
`timescale 1ns/1ps
interface mask_bus_if;
    import rail_fault_pkg::*;

    logic            wr_en;
    byte_t           addr;
    byte_t           wdata;
    regulator_mask_t regulator_mask;
    converter_mask_t converter_mask;

    // Register file side
    modport regs (
        input  wr_en,
        input  addr,
        input  wdata,
        output regulator_mask,
        output converter_mask
    );

    // Core side
    modport core (
        output wr_en,
        output addr,
        output wdata,
        input  regulator_mask,
        input  converter_mask
    );
endinterface

// File: rail_fault_mask_regs.sv
// Read/write storage of the two fault mask registers
`timescale 1ns/1ps
`include "rail_fault_defines.svh"
module rail_fault_mask_regs
    import rail_fault_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Core link
    mask_bus_if.regs bus
);

    regulator_mask_t regulator_fault_mask_reg;
    converter_mask_t converter_fault_mask_reg;

    // Regulator mask register, written whole
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            regulator_fault_mask_reg <= regulator_mask_t'(`MASK_RESET_VALUE);
        else if (bus.wr_en && bus.addr == `REGULATOR_MASK_ADDR)
            regulator_fault_mask_reg <= regulator_mask_t'(bus.wdata);
    end

    // Converter mask register, written whole
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            converter_fault_mask_reg <= converter_mask_t'(`MASK_RESET_VALUE);
        else if (bus.wr_en && bus.addr == `CONVERTER_MASK_ADDR)
            converter_fault_mask_reg <= converter_mask_t'(bus.wdata);
    end

    // Stored values steer the gating in the core
    assign bus.regulator_mask = regulator_fault_mask_reg;
    assign bus.converter_mask = converter_fault_mask_reg;

endmodule // rail_fault_mask_regs

// File: rail_fault_irq_mask.sv
// Fault event latching and mask gating of the active-low alert pin
//
// Operation
// R1: Regulator mask bit 7 blocks regulator-4 over-voltage
// R2: Regulator mask bit 6 blocks regulator-3 over-voltage
// R3: Regulator mask bit 5 blocks regulator-2 over-voltage
// R4: Regulator mask bit 4 blocks regulator-1 over-voltage
// R5: Regulator mask bits 3..0 block under-voltage 4..1
// R6: Converter mask bit 7 blocks step-up over-voltage
// R7: Converter mask bit 6 blocks step-down over-voltage
// R8: Converter mask bit 5 blocks step-up under-voltage
// R9: Converter mask bit 4 blocks step-down under-voltage
// R10: Converter mask bit 3 blocks regulator-4 over-current
// R11: Converter mask bit 2 blocks regulator-3 over-current
// R12: Converter mask bit 1 blocks regulator-2 over-current
// R13: Converter mask bit 0 blocks regulator-1 over-current
// R14: Alert low while any unmasked event pending
// R15: Masks gate only the pin, not detection
`timescale 1ns/1ps
`include "rail_fault_defines.svh"
module rail_fault_irq_mask
    import rail_fault_pkg::*;
#(
    parameter int EVENTS_PER_GROUP = 8
)
(
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        resetn,
    // Register access from the serial control bus slave
    input  wire logic [7:0]                  reg_addr,
    input  wire logic [7:0]                  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [7:0]                  reg_rdata,
    output logic                             reg_rvalid,
    // Raw fault detector levels, asynchronous
    input  wire logic [EVENTS_PER_GROUP-1:0] regulator_fault_evt,
    input  wire logic [EVENTS_PER_GROUP-1:0] converter_fault_evt,
    // Pending clears from the status block
    input  wire logic [EVENTS_PER_GROUP-1:0] regulator_pend_clear,
    input  wire logic [EVENTS_PER_GROUP-1:0] converter_pend_clear,
    // Pending view for the status block, masked and unmasked events alike
    output logic      [EVENTS_PER_GROUP-1:0] regulator_fault_pending,
    output logic      [EVENTS_PER_GROUP-1:0] converter_fault_pending,
    // Open-drain alert pin
    output logic                             fault_alert_n,
    output logic                             fault_alert_oe
);

    // Events handled as one vector, regulator group in the low half
    localparam int TOTAL_EVENTS = 2 * EVENTS_PER_GROUP;

    // Internal carrier to the register file
    mask_bus_if bus ();

    logic [TOTAL_EVENTS-1:0] evt_raw;
    logic [TOTAL_EVENTS-1:0] evt_meta_reg;
    logic [TOTAL_EVENTS-1:0] evt_sync_reg;
    logic [TOTAL_EVENTS-1:0] pend_clear;
    logic [TOTAL_EVENTS-1:0] pend_reg;
    logic [TOTAL_EVENTS-1:0] mask_vec;
    logic [TOTAL_EVENTS-1:0] unmasked;
    logic                    alert_active;
    byte_t                   read_next;
    regulator_mask_t         rmask;
    converter_mask_t         cmask;

    // Register file instance
    rail_fault_mask_regs u_regs (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .bus     (bus)
    );

    // Write path into the register file
    // Strobes come from the serial slave on this clock, so no sync stage
    assign bus.wr_en = reg_wr;
    assign bus.addr  = reg_addr;
    assign bus.wdata = reg_wdata;
    assign rmask     = bus.regulator_mask;
    assign cmask     = bus.converter_mask;

    // Event vector: converter group high, regulator group low
    assign evt_raw    = {converter_fault_evt, regulator_fault_evt};
    assign pend_clear = {converter_pend_clear, regulator_pend_clear};

    // Masks only gate the pin; the pending flags below never see them
    // Regulator group mask bits, aligned to the regulator events
    always_comb
    begin
        mask_vec = '0;
        mask_vec[`REG4_OVERVOLT_BIT]  = rmask.reg4_overvolt_mask; // R1
        mask_vec[`REG3_OVERVOLT_BIT]  = rmask.reg3_overvolt_mask; // R2
        mask_vec[`REG2_OVERVOLT_BIT]  = rmask.reg2_overvolt_mask; // R3
        mask_vec[`REG1_OVERVOLT_BIT]  = rmask.reg1_overvolt_mask; // R4
        mask_vec[`REG4_UNDERVOLT_BIT] = rmask.reg4_undervolt_mask; // R5
        mask_vec[`REG3_UNDERVOLT_BIT] = rmask.reg3_undervolt_mask; // R5
        mask_vec[`REG2_UNDERVOLT_BIT] = rmask.reg2_undervolt_mask; // R5
        mask_vec[`REG1_UNDERVOLT_BIT] = rmask.reg1_undervolt_mask; // R5
        // Converter group mask bits, shifted above the regulator group
        mask_vec[EVENTS_PER_GROUP + `STEPUP_OVERVOLT_BIT] =
            cmask.stepup_overvolt_mask; // R6
        mask_vec[EVENTS_PER_GROUP + `STEPDOWN_OVERVOLT_BIT] =
            cmask.stepdown_overvolt_mask; // R7
        mask_vec[EVENTS_PER_GROUP + `STEPUP_UNDERVOLT_BIT] =
            cmask.stepup_undervolt_mask; // R8
        mask_vec[EVENTS_PER_GROUP + `STEPDOWN_UNDERVOLT_BIT] =
            cmask.stepdown_undervolt_mask; // R9
        mask_vec[EVENTS_PER_GROUP + `REG4_OVERCURRENT_BIT] =
            cmask.reg4_overcurrent_mask; // R10
        mask_vec[EVENTS_PER_GROUP + `REG3_OVERCURRENT_BIT] =
            cmask.reg3_overcurrent_mask; // R11
        mask_vec[EVENTS_PER_GROUP + `REG2_OVERCURRENT_BIT] =
            cmask.reg2_overcurrent_mask; // R12
        mask_vec[EVENTS_PER_GROUP + `REG1_OVERCURRENT_BIT] =
            cmask.reg1_overcurrent_mask; // R13
    end

    // Per-event synchroniser, sticky pending flag and gate
    genvar i;
    generate
        for (i = 0; i < TOTAL_EVENTS; i++)
        begin : g_event
            // Two-stage synchroniser for the analog detector level
            // Detector levels bear no timing relation to ref_clk, so
            // nothing but the second stage reads the first
            always_ff @(posedge ref_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    evt_meta_reg[i] <= 1'b0;
                    evt_sync_reg[i] <= 1'b0;
                end
                else
                begin
                    evt_meta_reg[i] <= evt_raw[i];
                    evt_sync_reg[i] <= evt_meta_reg[i];
                end
            end

            // Pending flag: detection ignores the mask, set beats clear
            // A fault still present when the clear arrives stays flagged,
            // so a late clear cannot hide a live fault
            always_ff @(posedge ref_clk or negedge resetn)
            begin
                if (!resetn)
                    pend_reg[i] <= 1'b0;
                else if (evt_sync_reg[i])
                    pend_reg[i] <= 1'b1; // R15
                else if (pend_clear[i])
                    pend_reg[i] <= 1'b0;
            end

            // Masked events stay pending but cannot reach the pin
            assign unmasked[i] = pend_reg[i] & ~mask_vec[i]; // R15
        end
    endgenerate

    // Any unmasked pending event asserts the alert
    assign alert_active = |unmasked; // R14

    // Alert pin, driven low only while an unmasked event is pending
    // Registered so the pin stays glitch-free when masks and flags
    // change in the same cycle
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fault_alert_n  <= 1'b1;
            fault_alert_oe <= 1'b0;
        end
        else
        begin
            fault_alert_n  <= ~alert_active; // R14
            fault_alert_oe <= alert_active; // R14
        end
    end

    // Pending view for the status block, independent of masks
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            regulator_fault_pending <= '0;
            converter_fault_pending <= '0;
        end
        else
        begin
            regulator_fault_pending <= pend_reg[EVENTS_PER_GROUP-1:0]; // R15
            converter_fault_pending <= pend_reg[TOTAL_EVENTS-1:EVENTS_PER_GROUP]; // R15
        end
    end

    // Read data selection; other addresses read as zero
    always_comb
    begin
        read_next = `READ_IDLE_VALUE;
        case (reg_addr)
            `REGULATOR_MASK_ADDR: read_next = byte_t'(rmask);
            `CONVERTER_MASK_ADDR: read_next = byte_t'(cmask);
            default:              read_next = `READ_IDLE_VALUE;
        endcase
    end

    // Registered read answer, one cycle after the request
    // A read and a write of one place in the same cycle return the old value
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata  <= `READ_IDLE_VALUE;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= read_next;
        end
    end

endmodule // rail_fault_irq_mask

// File: rail_fault_irq_mask_asserts.sv
// Port-level checks of the fault mask block
`timescale 1ns/1ps
`include "rail_fault_defines.svh"
module rail_fault_irq_mask_asserts
#(
    parameter int EVENTS_PER_GROUP = 8
)
(
    // Clock, reset and register port
    input wire logic                        ref_clk,
    input wire logic                        resetn,
    input wire logic [7:0]                  reg_addr,
    input wire logic                        reg_rd,
    input wire logic [7:0]                  reg_rdata,
    input wire logic                        reg_rvalid,
    // Events, clears, flags and pin
    input wire logic [EVENTS_PER_GROUP-1:0] regulator_fault_evt,
    input wire logic [EVENTS_PER_GROUP-1:0] converter_fault_evt,
    input wire logic [EVENTS_PER_GROUP-1:0] regulator_pend_clear,
    input wire logic [EVENTS_PER_GROUP-1:0] converter_pend_clear,
    input wire logic [EVENTS_PER_GROUP-1:0] regulator_fault_pending,
    input wire logic [EVENTS_PER_GROUP-1:0] converter_fault_pending,
    input wire logic                        fault_alert_n,
    input wire logic                        fault_alert_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // Both groups joined
    wire [2*EVENTS_PER_GROUP-1:0] evt = {converter_fault_evt, regulator_fault_evt};
    wire [2*EVENTS_PER_GROUP-1:0] clr = {converter_pend_clear, regulator_pend_clear};
    wire [2*EVENTS_PER_GROUP-1:0] pend = {converter_fault_pending, regulator_fault_pending};
    // Events held long enough, masked or not
    sequence evt_held;
        $stable(evt) [*8];
    endsequence
    // Flags and pin
    chk_evt_pend: assert property (evt_held |-> (pend & evt) == evt)
        else $error("held event without flag");
    chk_pend_sticky: assert property (
        (($past(pend) & ~pend) & ~($past(clr) | $past(clr, 2))) == '0)
        else $error("flag dropped without clear");
    chk_alert_cause: assert property (!fault_alert_n |-> |pend)
        else $error("alert without pending flag");
    chk_oe_pin: assert property (fault_alert_oe == !fault_alert_n)
        else $error("enable and pin level disagree");
    // Read answers
    chk_rd_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    chk_no_stray: assert property (!reg_rd |=> !reg_rvalid)
        else $error("answer without read");
    chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    chk_unmapped_zero: assert property (
        reg_rd && reg_addr != `REGULATOR_MASK_ADDR && reg_addr != `CONVERTER_MASK_ADDR
        |=> reg_rdata == `READ_IDLE_VALUE)
        else $error("unmapped read not zero");
endmodule // rail_fault_irq_mask_asserts

bind rail_fault_irq_mask rail_fault_irq_mask_asserts #(
    .EVENTS_PER_GROUP(EVENTS_PER_GROUP)
) i_chk (
    .ref_clk, .resetn, .reg_addr, .reg_rd, .reg_rdata, .reg_rvalid,
    .regulator_fault_evt, .converter_fault_evt,
    .regulator_pend_clear, .converter_pend_clear,
    .regulator_fault_pending, .converter_fault_pending,
    .fault_alert_n, .fault_alert_oe
);

// File: alert_host_model.sv
// Host side of the open-drain alert line with its pull-up
`timescale 1ns/1ps
module alert_host_model
(
    // Pin from the device
    input wire logic fault_alert_n,
    input wire logic fault_alert_oe,
    // Level the host sees
    output logic     alert_line
);
    // Pull-up wins unless the device drives
    assign alert_line = fault_alert_oe ? fault_alert_n : 1'b1;
endmodule // alert_host_model

// File: tb_rail_fault_irq_mask.sv
// Self-checking bench of the fault mask block
`timescale 1ns/1ps
module tb_rail_fault_irq_mask
    import rail_fault_pkg::*;
;
    typedef struct {
        logic  conv;
        byte_t evt;
        byte_t mask;
        logic  exp_n;
    } row_t;
    // Design ports and bench state
    logic  ref_clk, resetn, reg_wr, reg_rd, reg_rvalid, fault_alert_n, fault_alert_oe, alert_line;
    byte_t reg_addr, reg_wdata, reg_rdata, regulator_fault_evt, converter_fault_evt;
    byte_t regulator_pend_clear, converter_pend_clear;
    byte_t regulator_fault_pending, converter_fault_pending;
    int    error_cnt, n_tests;
    row_t  rows[32];

    // 40 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    rail_fault_irq_mask i_dut (
        .ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
        .regulator_fault_evt, .converter_fault_evt, .regulator_pend_clear,
        .converter_pend_clear, .regulator_fault_pending, .converter_fault_pending,
        .fault_alert_n, .fault_alert_oe
    );
    alert_host_model i_host (.fault_alert_n, .fault_alert_oe, .alert_line);

    // Byte and bit compares
    task automatic chk8(byte_t got, byte_t exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(logic got, logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    // Register strobes, entered at a falling edge
    task automatic wr(byte_t a, byte_t d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(byte_t a, byte_t exp);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        chk1(reg_rvalid, 1'b1);
        chk8(reg_rdata, exp);
        // Let one edge pass so a following read never re-raises the strobe at once
        @(negedge ref_clk);
    endtask
    // One event under one mask, then dropped and cleared
    task automatic run_row(row_t r);
        wr(r.conv ? 8'h18 : 8'h17, r.mask);
        rd(r.conv ? 8'h18 : 8'h17, r.mask);
        {converter_fault_evt, regulator_fault_evt} = r.conv ? {r.evt, 8'h00} : {8'h00, r.evt};
        repeat (8) @(negedge ref_clk);
        chk1(alert_line, r.exp_n);
        chk8(r.conv ? converter_fault_pending : regulator_fault_pending, r.evt);
        {converter_fault_evt, regulator_fault_evt} = 16'h0000;
        repeat (4) @(negedge ref_clk);
        {converter_pend_clear, regulator_pend_clear} = 16'hffff;
        @(negedge ref_clk);
        {converter_pend_clear, regulator_pend_clear} = 16'h0000;
        repeat (3) @(negedge ref_clk);
        chk1(alert_line, 1'b1);
    endtask
    // Counts and verdict
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Run is about 640 cycles; cut off well beyond
    initial
    begin
        #100000;
        error_cnt++;
        results();
    end

    // Main sequence
    initial
    begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {regulator_fault_evt, converter_fault_evt, regulator_pend_clear, converter_pend_clear} = '0;
        error_cnt = 0;
        n_tests = 0;
        resetn = 1'b0;
        for (int k = 0; k < 32; k++)
        begin
            rows[k].conv = k[4];
            rows[k].evt = 8'h01 << k[2:0];
            rows[k].mask = k[3] ? ~rows[k].evt : rows[k].evt;
            rows[k].exp_n = ~k[3];
        end
        repeat (4) @(negedge ref_clk);
        resetn = 1'b1;
        rd(8'h17, 8'h00);
        rd(8'h18, 8'h00);
        $display("reset values done");
        foreach (rows[k])
            run_row(rows[k]);
        $display("mask rows done");
        // Unmapped place ignored, regulator mask untouched
        wr(8'h19, 8'hff);
        rd(8'h19, 8'h00);
        rd(8'h17, 8'h7f);
        $display("unmapped done");
        // Masked event pending, then unmasked; clear refused while high
        regulator_fault_evt = 8'h01;
        repeat (8) @(negedge ref_clk);
        chk1(alert_line, 1'b1);
        wr(8'h17, 8'h00);
        @(negedge ref_clk);
        chk1(alert_line, 1'b0);
        regulator_pend_clear = 8'h01;
        @(negedge ref_clk);
        regulator_pend_clear = 8'h00;
        repeat (3) @(negedge ref_clk);
        chk8(regulator_fault_pending, 8'h01);
        regulator_fault_evt = 8'h00;
        $display("unmask and refused clear done");
        // Reset in mid-run
        resetn = 1'b0;
        @(negedge ref_clk);
        chk1(alert_line, 1'b1);
        chk8(regulator_fault_pending, 8'h00);
        resetn = 1'b1;
        rd(8'h18, 8'h00);
        $display("second reset done");
        results();
    end
endmodule // tb_rail_fault_irq_mask
